/* verilog/scalar_int_float_unit.sv */
// scalar_int_float_unit: scalar integer/float datapath, backup registers, cycle counter
// assumes issue control presents operands with the opcode; result appears one clock later
//
// Notes on behaviour
// - integer sum; j=0 copies b; both zero top bit
// - integer difference; j=0 negates b; both zero top
// - floating sum always normalized, j=0 normalizes b
// - floating difference normalized, j=0 normalized negation
// - floating product, may stay unnormalized
// - half rounded product, low 24 bits zero
// - rounded floating product
// - two minus product, division correction step
// - reciprocal approximation of operand a
// - j=0 zero-extends address value, k=0 one
// - j=1 sign-extends address value, k=0 one
// - j=2 address as unnormalized float, k=0 one
// - j=3 writes 0.75 times two to 48
// - j=4..7 write 0.5, 1, 2, 4
// - read full cycle counter
// - cycle counter counts one per clock
// - read the lane mask register
// - read backup register chosen by jk
// - write Si source into backup jk
`timescale 1ns/100ps
module scalar_int_float_unit
  import scalar_unit_pkg::*;
#(
  parameter int BACKUP_DEPTH = 64
) (
  // clock and reset
  input  wire logic         CLOCK,
  input  wire logic         RESET,
  // instruction issue and operands
  input  wire logic         ISSUE_VALID,
  input  wire issue_s       ISSUE,
  input  wire word_t        SRC_A,
  input  wire word_t        SRC_B,
  input  wire word_t        SRC_I,
  input  wire logic [23:0]  ADDR_SRC,
  // lane mask load from vector compare, counter clear from software
  input  wire logic         MASK_LOAD,
  input  wire word_t        MASK_DATA,
  input  wire logic         COUNT_CLEAR,
  // scalar result write
  output logic              DEST_VALID,
  output logic [2:0]        DEST_INDEX,
  output word_t             DEST_DATA
);

  if (BACKUP_DEPTH != 64) begin : g_depth_check
    $error("BACKUP_DEPTH must be 64 to match the six-bit jk field");
  end

  // normalize a coefficient with one carry bit
  function automatic word_t fnorm(logic s, logic [15:0] e, logic [48:0] c);
    logic [15:0] ex;
    logic [48:0] cx;
    ex = e;
    cx = c;
    if (cx[48]) begin
      cx = cx >> 1;
      ex = ex + 16'h0001;
    end
    for (int n = 0; n < 48; n++) begin
      if (!cx[COEF_MSB] && cx != '0) begin
        cx = cx << 1;
        ex = ex - 16'h0001;
      end
    end
    return (cx == '0) ? word_t'(0) : {s, ex[14:0], cx[47:0]};
  endfunction

  function automatic word_t fadd(word_t a, word_t b);
    word_t hi;
    word_t lo;
    logic [48:0] ch;
    logic [48:0] cl;
    logic [48:0] t;
    logic [15:0] d;
    logic st;
    hi = (b[EXP_MSB:EXP_LSB] > a[EXP_MSB:EXP_LSB]) ? b : a;
    lo = (b[EXP_MSB:EXP_LSB] > a[EXP_MSB:EXP_LSB]) ? a : b;
    ch = {1'b0, hi[47:0]};
    d = {1'b0, hi[EXP_MSB:EXP_LSB]} - {1'b0, lo[EXP_MSB:EXP_LSB]};
    cl = (d > 16'h0030) ? 49'h0 : ({1'b0, lo[47:0]} >> d);
    if (hi[SIGN_POS] == lo[SIGN_POS]) begin
      t = ch + cl;
      st = hi[SIGN_POS];
    end else if (ch >= cl) begin
      t = ch - cl;
      st = hi[SIGN_POS];
    end else begin
      t = cl - ch;
      st = lo[SIGN_POS];
    end
    return fnorm(st, {1'b0, hi[EXP_MSB:EXP_LSB]}, t);
  endfunction

  function automatic word_t fmul(word_t a, word_t b, logic [1:0] mode);
    logic [96:0] p;
    logic [15:0] e;
    logic [47:0] c;
    p = 97'(a[47:0]) * 97'(b[47:0]);
    e = {1'b0, a[EXP_MSB:EXP_LSB]} + {1'b0, b[EXP_MSB:EXP_LSB]} - EXP_BIAS;
    if (!p[95]) begin
      p = p << 1;
      e = e - 16'h0001;
    end
    if (mode == RND_FULL) p = p + RND_FULL_BIT;
    if (mode == RND_HALF) p = p + RND_HALF_BIT;
    if (p[96]) begin
      p = p >> 1;
      e = e + 16'h0001;
    end
    c = p[95:48];
    if (mode == RND_HALF) c[HALF_BITS-1:0] = '0;
    if (a[47:0] == '0 || b[47:0] == '0) return word_t'(0);
    return {a[SIGN_POS] ^ b[SIGN_POS], e[14:0], c};
  endfunction

  function automatic word_t frecip(word_t a);
    logic [95:0] q;
    logic [15:0] e;
    q = RECIP_NUM / {48'h0, a[47:0]};
    e = EXP_RECIP - {1'b0, a[EXP_MSB:EXP_LSB]};
    if (a[47:0] == '0) return word_t'(0);
    // any quotient bit above the coefficient saturates to all ones
    return {a[SIGN_POS], e[14:0], (q[95:48] != 48'h0) ? COEF_MAX : q[47:0]};
  endfunction

  logic        valid_reg, valid_next;
  logic [2:0]  index_reg, index_next;
  word_t       data_reg, data_next;
  word_t       counter_reg, counter_next;
  word_t       lane_mask_reg, lane_mask_next;
  word_t       backup_reg [BACKUP_DEPTH];
  logic        backup_we;
  logic [5:0]  jk;
  word_t       opa;
  word_t       opb;

  assign jk = {ISSUE.j, ISSUE.k};

  always_comb begin
    // zero j gives a zero operand, zero k gives the top bit alone
    opa = (ISSUE.j == 3'h0) ? word_t'(0) : SRC_A;
    opb = (ISSUE.k == 3'h0) ? TOP_BIT : SRC_B;
    valid_next = 1'b0;
    index_next = ISSUE.i;
    data_next = data_reg;
    backup_we = 1'b0;
    counter_next = COUNT_CLEAR ? CNT_RESET : counter_reg + 64'h1;
    lane_mask_next = MASK_LOAD ? MASK_DATA : lane_mask_reg;
    if (ISSUE_VALID) begin
      valid_next = 1'b1;
      case (ISSUE.opcode)
        OP_INT_ADD:  data_next = opa + opb;
        OP_INT_SUB:  data_next = opa - opb;
        OP_FLT_ADD:  data_next = fadd(opa, opb);
        OP_FLT_SUB:  data_next = fadd(opa, opb ^ TOP_BIT);
        OP_FLT_MUL:  data_next = fmul(opa, opb, RND_NONE);
        OP_FLT_HMUL: data_next = fmul(opa, opb, RND_HALF);
        OP_FLT_RMUL: data_next = fmul(opa, opb, RND_FULL);
        OP_RECIP_IT: data_next = fadd(FLT_TWO, fmul(opa, opb, RND_NONE) ^ TOP_BIT);
        OP_RECIP_AP: data_next = frecip(opa);
        OP_ADDR_XFR: begin
          unique case (ISSUE.j)
            3'h0: data_next = (ISSUE.k == 3'h0) ? INT_ONE : {40'h0, ADDR_SRC};
            3'h1: data_next = (ISSUE.k == 3'h0) ? INT_ONE
                              : {{40{ADDR_SRC[ADDR_W-1]}}, ADDR_SRC};
            3'h2: data_next = (ISSUE.k == 3'h0) ? FLT_UONE
                              : {1'b0, EXP_UNNORM[14:0], 24'h0, ADDR_SRC};
            3'h3: data_next = FLT_FIX;
            3'h4: data_next = FLT_HALF;
            3'h5: data_next = FLT_ONE;
            3'h6: data_next = FLT_TWO;
            3'h7: data_next = FLT_FOUR;
          endcase
        end
        OP_CNT_READ: data_next = counter_reg;
        OP_MASK_RD:  data_next = lane_mask_reg;
        OP_BACK_RD:  data_next = backup_reg[jk];
        OP_BACK_WR: begin
          valid_next = 1'b0;
          backup_we = 1'b1;
        end
        default:     valid_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      valid_reg <= 1'b0;
      index_reg <= 3'h0;
      data_reg <= word_t'(0);
      counter_reg <= CNT_RESET;
      lane_mask_reg <= word_t'(0);
    end else begin
      valid_reg <= valid_next;
      index_reg <= index_next;
      data_reg <= data_next;
      counter_reg <= counter_next;
      lane_mask_reg <= lane_mask_next;
    end
  end

  // backup file holds no reset; only the store opcode writes it
  always_ff @(posedge CLOCK) begin
    if (backup_we) begin
      backup_reg[jk] <= SRC_I;
    end
  end

  assign DEST_VALID = valid_reg;
  assign DEST_INDEX = index_reg;
  assign DEST_DATA  = data_reg;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  logic go;
  assign go = ISSUE_VALID;

  sequence s_store;
    go && ISSUE.opcode == OP_BACK_WR;
  endsequence
  sequence s_fetch_same;
    go && ISSUE.opcode == OP_BACK_RD && jk == $past(jk);
  endsequence

  a_int_sum_value: assert property (
    go && ISSUE.opcode == OP_INT_ADD && ISSUE.j != 3'h0 && ISSUE.k != 3'h0
    |=> DEST_VALID && DEST_DATA == $past(SRC_A) + $past(SRC_B))
    else $error("integer sum wrong");
  a_int_sum_zero: assert property (
    go && ISSUE.opcode == OP_INT_ADD && jk == 6'h00 |=> DEST_DATA == TOP_BIT)
    else $error("integer sum with zero designators wrong");
  a_int_diff_neg: assert property (
    go && ISSUE.opcode == OP_INT_SUB && ISSUE.j == 3'h0 && ISSUE.k != 3'h0
    |=> DEST_DATA == word_t'(0) - $past(SRC_B))
    else $error("negation of operand b wrong");
  a_fadd_normal: assert property (
    go && ISSUE.opcode == OP_FLT_ADD |=> DEST_DATA[COEF_MSB] || DEST_DATA == word_t'(0))
    else $error("floating sum not normalized");
  a_fsub_normal: assert property (
    go && ISSUE.opcode == OP_FLT_SUB |=> DEST_DATA[COEF_MSB] || DEST_DATA == word_t'(0))
    else $error("floating difference not normalized");
  a_half_low_clear: assert property (
    go && ISSUE.opcode == OP_FLT_HMUL |=> DEST_VALID && DEST_DATA[HALF_BITS-1:0] == '0)
    else $error("half product low bits not cleared");
  a_addr_zero_ext: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j == 3'h0 && ISSUE.k != 3'h0
    |=> DEST_DATA == {40'h0, $past(ADDR_SRC)})
    else $error("zero extension wrong");
  a_addr_sign_ext: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j == 3'h1 && ISSUE.k != 3'h0
    |=> DEST_DATA[63:ADDR_W] == {40{$past(ADDR_SRC[ADDR_W-1])}})
    else $error("sign extension wrong");
  a_const_one: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j == 3'h5 |=> DEST_DATA == FLT_ONE)
    else $error("floating one constant wrong");
  a_count_step: assert property (
    !RESET && !COUNT_CLEAR |=> counter_reg == $past(counter_reg) + 64'h1)
    else $error("cycle counter did not step by one");
  a_count_read: assert property (
    go && ISSUE.opcode == OP_CNT_READ && !COUNT_CLEAR |=> DEST_DATA + 64'h1 == counter_reg)
    else $error("counter read wrong");
  a_mask_read: assert property (
    go && ISSUE.opcode == OP_MASK_RD |=> DEST_DATA == $past(lane_mask_reg))
    else $error("lane mask read wrong");
  a_backup_trip: assert property (
    s_store ##1 s_fetch_same |=> DEST_VALID && DEST_DATA == $past(SRC_I, 2))
    else $error("backup register round trip wrong");
  a_store_quiet: assert property (
    s_store |=> !DEST_VALID)
    else $error("backup store wrote a scalar result");
  a_refuse_quiet: assert property (
    go && !(ISSUE.opcode inside {[OP_INT_ADD:OP_BACK_WR]}) |=> !DEST_VALID)
    else $error("unknown opcode wrote a scalar result");
  a_result_index: assert property (
    go && ISSUE.opcode inside {[OP_INT_ADD:OP_BACK_RD]}
    |=> DEST_VALID && DEST_INDEX == $past(ISSUE.i))
    else $error("result index or strobe wrong");
  a_addr_unnorm: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j == 3'h2 && ISSUE.k != 3'h0
    |=> DEST_DATA == {1'b0, EXP_UNNORM[14:0], 24'h0, $past(ADDR_SRC)})
    else $error("unnormalized address transfer wrong");
  a_addr_one: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j inside {3'h0, 3'h1} && ISSUE.k == 3'h0
    |=> DEST_DATA == INT_ONE)
    else $error("integer one for zero k wrong");
  a_fix_const: assert property (
    go && ISSUE.opcode == OP_ADDR_XFR && ISSUE.j == 3'h3 |=> DEST_DATA == FLT_FIX)
    else $error("integer extraction constant wrong");
  a_mul_sign: assert property (
    go && ISSUE.opcode == OP_FLT_MUL && ISSUE.j != 3'h0 && ISSUE.k != 3'h0
    && SRC_A[47:0] != 48'h0 && SRC_B[47:0] != 48'h0
    |=> DEST_DATA[SIGN_POS] == ($past(SRC_A[SIGN_POS]) ^ $past(SRC_B[SIGN_POS])))
    else $error("floating product sign wrong");
  a_recip_sign: assert property (
    go && ISSUE.opcode == OP_RECIP_AP && ISSUE.j != 3'h0 && SRC_A[47:0] != 48'h0
    |=> DEST_DATA[SIGN_POS] == $past(SRC_A[SIGN_POS]))
    else $error("reciprocal sign wrong");
endmodule

/* verilog/scalar_unit_pkg.sv */
// scalar_unit_pkg: opcodes, float layout and constants of the scalar unit
// assumes one system clock and the word format sign, 15-bit exponent, 48-bit coefficient
package scalar_unit_pkg;
  typedef logic [63:0] word_t;

  typedef struct packed {
    logic [6:0] opcode;
    logic [2:0] i;
    logic [2:0] j;
    logic [2:0] k;
  } issue_s;

  localparam logic [6:0] OP_INT_ADD  = 7'h30;
  localparam logic [6:0] OP_INT_SUB  = 7'h31;
  localparam logic [6:0] OP_FLT_ADD  = 7'h32;
  localparam logic [6:0] OP_FLT_SUB  = 7'h33;
  localparam logic [6:0] OP_FLT_MUL  = 7'h34;
  localparam logic [6:0] OP_FLT_HMUL = 7'h35;
  localparam logic [6:0] OP_FLT_RMUL = 7'h36;
  localparam logic [6:0] OP_RECIP_IT = 7'h37;
  localparam logic [6:0] OP_RECIP_AP = 7'h38;
  localparam logic [6:0] OP_ADDR_XFR = 7'h39;
  localparam logic [6:0] OP_CNT_READ = 7'h3A;
  localparam logic [6:0] OP_MASK_RD  = 7'h3B;
  localparam logic [6:0] OP_BACK_RD  = 7'h3C;
  localparam logic [6:0] OP_BACK_WR  = 7'h3D;

  localparam int SIGN_POS  = 63;
  localparam int EXP_MSB   = 62;
  localparam int EXP_LSB   = 48;
  localparam int COEF_MSB  = 47;
  localparam int HALF_BITS = 24;
  localparam int ADDR_W    = 24;

  localparam logic [15:0] EXP_BIAS   = 16'h4000;
  localparam logic [15:0] EXP_RECIP  = 16'h8001;
  localparam logic [15:0] EXP_UNNORM = 16'h4030;
  localparam word_t TOP_BIT   = 64'h8000_0000_0000_0000;
  localparam word_t INT_ONE   = 64'h0000_0000_0000_0001;
  localparam word_t FLT_UONE  = 64'h4030_0000_0000_0001;
  localparam word_t FLT_FIX   = 64'h4030_C000_0000_0000;
  localparam word_t FLT_HALF  = 64'h4000_8000_0000_0000;
  localparam word_t FLT_ONE   = 64'h4001_8000_0000_0000;
  localparam word_t FLT_TWO   = 64'h4002_8000_0000_0000;
  localparam word_t FLT_FOUR  = 64'h4003_8000_0000_0000;
  localparam word_t CNT_RESET = 64'h0;

  localparam logic [1:0] RND_NONE = 2'h0;
  localparam logic [1:0] RND_FULL = 2'h1;
  localparam logic [1:0] RND_HALF = 2'h2;
  localparam logic [96:0] RND_FULL_BIT = 97'h0_0000_0000_0000_8000_0000_0000;
  localparam logic [96:0] RND_HALF_BIT = 97'h0_0000_0080_0000_0000_0000_0000;
  localparam logic [95:0] RECIP_NUM    = 96'h8000_0000_0000_0000_0000_0000;
  localparam logic [47:0] COEF_MAX     = 48'hFFFF_FFFF_FFFF;
endpackage

/* verification/issue_ctrl_model.sv */
// issue_ctrl_model: scalar register file and start-up software seen by the scalar unit
// assumes one system clock; a result write lands in the register named by its index
`timescale 1ns/100ps
module issue_ctrl_model
  import scalar_unit_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // result write from the scalar unit
  input  wire logic       dest_valid,
  input  wire logic [2:0] dest_index,
  input  wire word_t      dest_data,
  // counter clear issued once by start-up software
  output logic            count_clear
);
  word_t sreg [8];
  logic  rst_d;

  always_ff @(posedge clk) begin
    rst_d <= rst;
    // one pulse on the first edge after reset is released
    count_clear <= rst_d & ~rst;
    if (dest_valid) begin
      sreg[dest_index] <= dest_data;
    end
  end
endmodule

/* verification/scalar_int_float_unit_tb_top.sv */
// scalar_int_float_unit_tb_top: table of single instructions, then hand-made cases
// assumes the result of an issue shows one clock after the issue edge
`timescale 1ns/100ps
module scalar_int_float_unit_tb_top
  import scalar_unit_pkg::*;
;
  typedef struct packed {
    issue_s      iss;
    word_t       a;
    word_t       b;
    logic [23:0] ad;
    word_t       e;
    word_t       m;
  } row_s;
  localparam word_t F   = '1;
  localparam word_t NL  = ~64'h1;
  localparam word_t W6  = 64'h0123_4567_89AB_CDEF;
  localparam word_t W63 = 64'hFEDC_BA98_7654_3210;
  localparam row_s ROWS [29] = '{
    '{'{OP_INT_ADD, 3'h2, 3'h3, 3'h7}, 64'h5, 64'h7, 24'h0, 64'hC, F},
    '{'{OP_INT_ADD, 3'h4, 3'h0, 3'h5}, 64'h5, 64'h1234, 24'h0, 64'h1234, F},
    '{'{OP_INT_ADD, 3'h1, 3'h0, 3'h0}, 64'h5, 64'h7, 24'h0, TOP_BIT, F},
    '{'{OP_INT_SUB, 3'h1, 3'h2, 3'h3}, 64'h3, 64'h5, 24'h0, ~64'h1, F},
    '{'{OP_INT_SUB, 3'h5, 3'h0, 3'h6}, 64'h9, 64'h1, 24'h0, F, F},
    '{'{OP_INT_SUB, 3'h6, 3'h0, 3'h0}, 64'h9, 64'h1, 24'h0, TOP_BIT, F},
    '{'{OP_FLT_ADD, 3'h3, 3'h4, 3'h5}, FLT_ONE, FLT_ONE, 24'h0, FLT_TWO, F},
    '{'{OP_FLT_ADD, 3'h7, 3'h0, 3'h5}, 64'h5, FLT_UONE, 24'h0, FLT_ONE, F},
    '{'{OP_FLT_SUB, 3'h7, 3'h6, 3'h1}, FLT_FOUR, FLT_TWO, 24'h0, FLT_TWO, F},
    '{'{OP_FLT_SUB, 3'h1, 3'h0, 3'h2}, 64'h5, FLT_TWO, 24'h0, 64'hC002_8000_0000_0000, F},
    '{'{OP_FLT_MUL, 3'h2, 3'h3, 3'h4}, FLT_TWO, FLT_TWO, 24'h0, FLT_FOUR, F},
    '{'{OP_FLT_MUL, 3'h2, 3'h3, 3'h4}, FLT_ONE | 64'h1, FLT_ONE, 24'h0, FLT_ONE | 64'h1, F},
    '{'{OP_FLT_HMUL, 3'h1, 3'h6, 3'h7}, FLT_ONE | 64'h1, FLT_ONE, 24'h0, FLT_ONE, F},
    '{'{OP_FLT_RMUL, 3'h1, 3'h4, 3'h7}, FLT_TWO, FLT_TWO, 24'h0, FLT_FOUR, NL},
    '{'{OP_RECIP_IT, 3'h3, 3'h2, 3'h3}, FLT_ONE, FLT_ONE, 24'h0, FLT_ONE, NL},
    '{'{OP_RECIP_AP, 3'h3, 3'h2, 3'h1}, FLT_ONE, 64'h0, 24'h0, 64'h4000_FFFF_FFFF_FFFF,
      64'hFFFF_FFFF_0000_0000},
    '{'{OP_ADDR_XFR, 3'h2, 3'h0, 3'h3}, 64'h0, 64'h0, 24'hABCDEF, 64'hAB_CDEF, F},
    '{'{OP_ADDR_XFR, 3'h2, 3'h0, 3'h0}, 64'h0, 64'h0, 24'hABCDEF, INT_ONE, F},
    '{'{OP_ADDR_XFR, 3'h3, 3'h1, 3'h4}, 64'h0, 64'h0, 24'h800001, 64'hFFFF_FFFF_FF80_0001, F},
    '{'{OP_ADDR_XFR, 3'h3, 3'h1, 3'h0}, 64'h0, 64'h0, 24'h800001, INT_ONE, F},
    '{'{OP_ADDR_XFR, 3'h4, 3'h2, 3'h5}, 64'h0, 64'h0, 24'h000123, 64'h4030_0000_0000_0123, F},
    '{'{OP_ADDR_XFR, 3'h4, 3'h2, 3'h0}, 64'h0, 64'h0, 24'h000123, FLT_UONE, F},
    '{'{OP_ADDR_XFR, 3'h5, 3'h3, 3'h1}, 64'h0, 64'h0, 24'h0, FLT_FIX, F},
    '{'{OP_ADDR_XFR, 3'h6, 3'h4, 3'h1}, 64'h0, 64'h0, 24'h0, FLT_HALF, F},
    '{'{OP_ADDR_XFR, 3'h7, 3'h5, 3'h1}, 64'h0, 64'h0, 24'h0, FLT_ONE, F},
    '{'{OP_ADDR_XFR, 3'h0, 3'h6, 3'h1}, 64'h0, 64'h0, 24'h0, FLT_TWO, F},
    '{'{OP_ADDR_XFR, 3'h1, 3'h7, 3'h1}, 64'h0, 64'h0, 24'h0, FLT_FOUR, F},
    '{'{OP_MASK_RD, 3'h6, 3'h0, 3'h0}, 64'h0, 64'h0, 24'h0, 64'h0, F},
    '{'{OP_INT_ADD, 3'h7, 3'h7, 3'h7}, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2, 24'h0, 64'h1, F}
  };

  logic        CLOCK;
  logic        RESET;
  logic        ISSUE_VALID;
  issue_s      ISSUE;
  word_t       SRC_A;
  word_t       SRC_B;
  word_t       SRC_I;
  logic [23:0] ADDR_SRC;
  logic        MASK_LOAD;
  word_t       MASK_DATA;
  logic        COUNT_CLEAR;
  logic        DEST_VALID;
  logic [2:0]  DEST_INDEX;
  word_t       DEST_DATA;
  word_t       tb_cnt;
  int          fail_count;
  int          total_checks;

  scalar_int_float_unit #(.BACKUP_DEPTH(64)) DUT (.CLOCK(CLOCK), .RESET(RESET),
    .ISSUE_VALID(ISSUE_VALID), .ISSUE(ISSUE), .SRC_A(SRC_A), .SRC_B(SRC_B), .SRC_I(SRC_I),
    .ADDR_SRC(ADDR_SRC), .MASK_LOAD(MASK_LOAD), .MASK_DATA(MASK_DATA),
    .COUNT_CLEAR(COUNT_CLEAR), .DEST_VALID(DEST_VALID), .DEST_INDEX(DEST_INDEX),
    .DEST_DATA(DEST_DATA));
  issue_ctrl_model PART (.clk(CLOCK), .rst(RESET), .dest_valid(DEST_VALID),
    .dest_index(DEST_INDEX), .dest_data(DEST_DATA), .count_clear(COUNT_CLEAR));

  initial CLOCK = 1'b0;
  always #12.5 CLOCK = ~CLOCK;
  // mirror of the cycle counter, cleared by the same pulse
  always @(posedge CLOCK) tb_cnt <= COUNT_CLEAR ? 64'h0 : tb_cnt + 64'h1;

  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check_word(input string nm, input word_t e, input word_t g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic check_flag(input string nm, input logic [2:0] e, input logic [2:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // called right after a rising edge; last drops the strobe after the taking edge
  task automatic send(input issue_s iss, input word_t a, input word_t b, input word_t si,
                      input logic [23:0] ad, input bit last);
    ISSUE_VALID <= 1'b1;
    ISSUE <= iss;
    SRC_A <= a;
    SRC_B <= b;
    SRC_I <= si;
    ADDR_SRC <= ad;
    @(posedge CLOCK);
    if (last) begin
      ISSUE_VALID <= 1'b0;
    end
  endtask

  task automatic res(input string nm, input word_t e, input word_t m, input logic [2:0] idx);
    @(negedge CLOCK);
    check_flag({nm, "_valid"}, 3'h1, {2'h0, DEST_VALID});
    check_flag({nm, "_index"}, idx, DEST_INDEX);
    check_word(nm, e & m, DEST_DATA & m);
    @(posedge CLOCK);
  endtask

  initial begin
    repeat (2000) @(posedge CLOCK);
    fail_count++;
    finish_test();
  end

  initial begin
    {ISSUE_VALID, ISSUE, SRC_A, SRC_B, SRC_I, ADDR_SRC, MASK_LOAD, MASK_DATA} = '0;
    RESET = 1'b1;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge CLOCK);
    RESET <= 1'b0;
    @(negedge CLOCK);
    check_flag("rst_valid", 3'h0, {2'h0, DEST_VALID});
    check_word("rst_data", 64'h0, DEST_DATA);
    @(posedge CLOCK);
    for (int n = 0; n < 29; n++) begin
      send(ROWS[n].iss, ROWS[n].a, ROWS[n].b, 64'h0, ROWS[n].ad, 1'b1);
      res($sformatf("row%0d", n), ROWS[n].e, ROWS[n].m, ROWS[n].iss.i);
    end
    send('{7'h2F, 3'h1, 3'h1, 3'h1}, 64'h1, 64'h1, 64'h0, 24'h0, 1'b1);
    @(negedge CLOCK);
    check_flag("refused", 3'h0, {2'h0, DEST_VALID});
    @(posedge CLOCK);
    send('{OP_BACK_WR, 3'h1, 3'h7, 3'h7}, 64'h0, 64'h0, W63, 24'h0, 1'b1);
    @(negedge CLOCK);
    check_flag("bk_none", 3'h0, {2'h0, DEST_VALID});
    @(posedge CLOCK);
    send('{OP_BACK_WR, 3'h2, 3'h0, 3'h6}, 64'h0, 64'h0, W6, 24'h0, 1'b0);
    send('{OP_BACK_RD, 3'h4, 3'h0, 3'h6}, 64'h0, 64'h0, 64'h0, 24'h0, 1'b1);
    res("bk6", W6, F, 3'h4);
    send('{OP_BACK_RD, 3'h5, 3'h7, 3'h7}, 64'h0, 64'h0, 64'h0, 24'h0, 1'b1);
    res("bk63", W63, F, 3'h5);
    MASK_DATA <= 64'hF0F0_0000_A5A5_0001;
    MASK_LOAD <= 1'b1;
    @(posedge CLOCK);
    MASK_LOAD <= 1'b0;
    send('{OP_MASK_RD, 3'h3, 3'h0, 3'h0}, 64'h0, 64'h0, 64'h0, 24'h0, 1'b1);
    res("mask", 64'hF0F0_0000_A5A5_0001, F, 3'h3);
    send('{OP_CNT_READ, 3'h1, 3'h0, 3'h0}, 64'h0, 64'h0, 64'h0, 24'h0, 1'b0);
    send('{OP_CNT_READ, 3'h2, 3'h0, 3'h0}, 64'h0, 64'h0, 64'h0, 24'h0, 1'b1);
    @(negedge CLOCK);
    check_word("cnt", tb_cnt - 64'h1, DEST_DATA);
    @(negedge CLOCK);
    check_word("cnt_prev", tb_cnt - 64'h3, PART.sreg[1]);
    finish_test();
  end
endmodule
